// ===== coherent_codec_pkg.sv
package coherent_codec_pkg;

  // Field widths of the logical packet header.
  localparam int FMT_W = 4;
  localparam int TT_W = 4;
  localparam int ST_W = 4;
  localparam int SZ_W = 4;

  // Format codes.
  localparam logic [3:0] FMT_INTERVENTION = 4'h1;
  localparam logic [3:0] FMT_REQUEST = 4'h2;
  localparam logic [3:0] FMT_WRITE = 4'h5;
  localparam logic [3:0] FMT_RESPONSE = 4'hD;
  localparam logic [3:0] FMT_IMPL_LOW = 4'h0;
  localparam logic [3:0] FMT_IMPL_HIGH = 4'hF;

  // Intervention-request transactions.
  localparam logic [3:0] TT1_READ_SHARED_OWNER = 4'h0;
  localparam logic [3:0] TT1_ITEM_A = 4'h1;
  localparam logic [3:0] TT1_IO_READ_OWNER = 4'h2;
  localparam logic [3:0] TT1_LAST = 4'h2;

  // Plain request transactions.
  localparam logic [3:0] TT2_READ_SHARED_HOME = 4'h0;
  localparam logic [3:0] TT2_ITEM_B = 4'h1;
  localparam logic [3:0] TT2_IO_READ_HOME = 4'h2;
  localparam logic [3:0] TT2_DATA_KILL_HOME = 4'h3;
  localparam logic [3:0] TT2_RESERVED_GAP = 4'h4;
  localparam logic [3:0] TT2_INSTR_KILL_HOME = 4'h5;
  localparam logic [3:0] TT2_TRANSLATION_INVALIDATE = 4'h6;
  localparam logic [3:0] TT2_TRANSLATION_SYNC = 4'h7;
  localparam logic [3:0] TT2_INSTR_READ_HOME = 4'h8;
  localparam logic [3:0] TT2_FLUSH_NO_DATA = 4'h9;
  localparam logic [3:0] TT2_INSTR_KILL_SHARER = 4'hA;
  localparam logic [3:0] TT2_DATA_KILL_SHARER = 4'hB;

  // Write-class transactions.
  localparam logic [3:0] TT5_OWNERSHIP_WRITEBACK = 4'h0;
  localparam logic [3:0] TT5_FLUSH_WITH_DATA = 4'h1;
  localparam logic [3:0] TT5_LAST = 4'h1;

  // Response transactions.
  localparam logic [3:0] TT13_NO_DATA = 4'h0;
  localparam logic [3:0] TT13_WITH_DATA = 4'h8;

  // Response status codes.
  localparam logic [3:0] ST_DONE = 4'h0;
  localparam logic [3:0] ST_DATA_ONLY = 4'h1;
  localparam logic [3:0] ST_NOT_OWNER = 4'h2;
  localparam logic [3:0] ST_RETRY = 4'h3;
  localparam logic [3:0] ST_INTERVENTION = 4'h4;
  localparam logic [3:0] ST_DONE_INTERVENTION = 4'h5;
  localparam logic [3:0] ST_RESERVED_GAP = 4'h6;
  localparam logic [3:0] ST_FAULT = 4'h7;
  localparam logic [3:0] ST_IMPL_FIRST = 4'hC;

  // Role of this processing element.
  typedef enum logic [1:0] {
    ROLE_REQUESTER,
    ROLE_HOME,
    ROLE_SHARER
  } role_e;

  // Kind of packet a user asks the generator to build.
  typedef enum logic [1:0] {
    KIND_INTERVENTION,
    KIND_REQUEST,
    KIND_WRITE,
    KIND_RESPONSE
  } kind_e;

endpackage

// ===== coherent_rx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module coherent_rx_checker
  import coherent_codec_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic rx_valid, // Received header is present.
  input wire logic [FMT_W-1:0] rx_format, // Received format code.
  input wire logic [TT_W-1:0] rx_transaction, // Received transaction code.
  input wire logic [ST_W-1:0] rx_status, // Received response status.
  output logic rx_accept, // Pulse: header is a defined transaction.
  output logic rx_impl_defined, // Pulse: implementation-defined format.
  output logic rx_error // Pulse: reserved encoding where one is required.
);

  logic next_accept;
  logic next_impl;
  logic next_error;

  always_comb begin
    next_accept = 1'b0;
    next_impl = 1'b0;
    next_error = 1'b0;
    if (rx_valid) begin
      case (rx_format)
        FMT_INTERVENTION: next_error = rx_transaction > TT1_LAST;
        FMT_REQUEST: next_error = rx_transaction == TT2_RESERVED_GAP ||
                                  rx_transaction > TT2_DATA_KILL_SHARER;
        FMT_WRITE: next_error = rx_transaction > TT5_LAST;
        FMT_RESPONSE: begin
          // Implementation-defined status codes are accepted; only reserved ones fault.
          next_error = (rx_transaction != TT13_NO_DATA && rx_transaction != TT13_WITH_DATA) ||
                       rx_status == ST_RESERVED_GAP ||
                       (rx_status > ST_FAULT && rx_status < ST_IMPL_FIRST);
        end
        FMT_IMPL_LOW, FMT_IMPL_HIGH: next_impl = 1'b1;
        default: next_error = 1'b1;
      endcase
      next_accept = !next_error && !next_impl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_accept <= 1'b0;
      rx_impl_defined <= 1'b0;
      rx_error <= 1'b0;
    end else begin
      rx_accept <= next_accept;
      rx_impl_defined <= next_impl;
      rx_error <= next_error;
    end
  end

endmodule
`default_nettype wire

// ===== coherent_memory_packet_codec.sv
`timescale 1ns/1ps
`default_nettype none
module coherent_memory_packet_codec
  import coherent_codec_pkg::*;
#(
  parameter int DOMAIN_W = 4, // Secondary domain width.
  parameter int DEVICE_W = 4, // Secondary device width.
  parameter int TAG_W = 8, // Transaction tag width.
  parameter int ADDR_W = 29, // Double-word address width.
  parameter int XMSB_W = 2 // Extended address top bits.
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire role_e role, // Role of this processing element.
  input wire logic gen_valid, // Request to build one header.
  input wire kind_e gen_kind, // Which packet class to build.
  input wire logic [TT_W-1:0] gen_transaction, // Transaction code.
  input wire logic [ST_W-1:0] gen_status, // Response status.
  input wire logic gen_has_payload, // Response carries data if allowed.
  input wire logic [SZ_W-1:0] gen_size, // Read or write size.
  input wire logic gen_word_pointer, // Word pointer.
  input wire logic [ADDR_W-1:0] gen_address, // Double-word address.
  input wire logic [XMSB_W-1:0] gen_address_top, // Extended address top bits.
  input wire logic [TAG_W-1:0] gen_tag, // Own or answered request tag.
  input wire logic [DOMAIN_W-1:0] gen_original_domain, // Original requester domain.
  input wire logic [DEVICE_W-1:0] gen_original_device, // Original requester device.
  input wire logic [TAG_W-1:0] gen_original_tag, // Original requester tag.
  input wire logic tx_ready, // Serializer takes the next bit.
  output logic gen_ready, // Generator idle and able to take a header.
  output logic gen_refused, // Pulse: request illegal for role or code.
  output logic tx_valid, // Serial bit stream is valid.
  output logic tx_bit, // Current serial bit.
  output logic tx_last, // Last bit of the header.
  output logic tx_payload_follows, // Level: a payload follows this header.
  input wire logic rx_valid, // Received header is present.
  input wire logic [FMT_W-1:0] rx_format, // Received format code.
  input wire logic [TT_W-1:0] rx_transaction, // Received transaction code.
  input wire logic [ST_W-1:0] rx_status, // Received response status.
  output logic rx_accept, // Pulse: defined transaction received.
  output logic rx_impl_defined, // Pulse: implementation-defined format.
  output logic rx_error // Pulse: reserved encoding received.
);

  // Header layout, most significant bit sent first: format, transaction, then body.
  localparam int BODY_W = DOMAIN_W + DEVICE_W + TAG_W + TAG_W + SZ_W + 1 + XMSB_W + ADDR_W;
  localparam int HDR_W = FMT_W + TT_W + BODY_W;
  localparam int CNT_W = $clog2(HDR_W + 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(HDR_W - 1);

  typedef enum logic [1:0] {
    S_IDLE,
    S_SHIFT
  } state_e;

  //////////////////////////////////////////////////////////////////////////////

  // Address-only request kinds carry no size or pointer.
  function automatic logic address_only(input logic [TT_W-1:0] tt);
    address_only = tt == TT2_DATA_KILL_HOME || tt == TT2_INSTR_KILL_HOME ||
                   tt == TT2_DATA_KILL_SHARER || tt == TT2_INSTR_KILL_SHARER ||
                   tt == TT2_FLUSH_NO_DATA || tt == TT2_TRANSLATION_INVALIDATE;
  endfunction

  // Decides whether this role may originate the requested packet.
  function automatic logic legal_request(input kind_e kind, input logic [TT_W-1:0] tt,
                                         input logic [ST_W-1:0] st, input role_e r);
    legal_request = 1'b0;
    case (kind)
      KIND_INTERVENTION: legal_request = r == ROLE_HOME && tt <= TT1_LAST;
      KIND_REQUEST: begin
        if (tt == TT2_DATA_KILL_SHARER || tt == TT2_INSTR_KILL_SHARER) begin
          legal_request = r == ROLE_HOME;
        end else begin
          legal_request = tt != TT2_RESERVED_GAP && tt <= TT2_DATA_KILL_SHARER;
        end
      end
      KIND_WRITE: legal_request = tt <= TT5_LAST;
      KIND_RESPONSE: legal_request = st != ST_RESERVED_GAP && !(st > ST_FAULT && st < ST_IMPL_FIRST);
      default: legal_request = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  state_e state;
  state_e next_state;
  logic [HDR_W-1:0] shift;
  logic [HDR_W-1:0] next_shift;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_gen_ready;
  logic next_refused;
  logic next_tx_valid;
  logic next_tx_bit;
  logic next_tx_last;
  logic next_payload;
  logic payload;
  logic [FMT_W-1:0] fmt;
  logic [TT_W-1:0] tt;
  logic [DOMAIN_W-1:0] dom;
  logic [DEVICE_W-1:0] dev;
  logic [TAG_W-1:0] orig_tag;
  logic [SZ_W-1:0] size;
  logic wptr;
  logic [XMSB_W-1:0] top;
  logic [ADDR_W-1:0] addr;
  logic [HDR_W-1:0] header;

  // Field assembly; unused fields stay zero as reserved bits.
  always_comb begin
    fmt = FMT_REQUEST;
    tt = gen_transaction;
    dom = '0;
    dev = '0;
    orig_tag = '0;
    size = gen_size;
    wptr = gen_word_pointer;
    top = gen_address_top;
    addr = gen_address;
    payload = 1'b0;
    case (gen_kind)
      KIND_INTERVENTION: begin
        fmt = FMT_INTERVENTION;
        dom = gen_original_domain;
        dev = gen_original_device;
        orig_tag = gen_original_tag;
      end
      KIND_REQUEST: begin
        fmt = FMT_REQUEST;
        if (address_only(gen_transaction)) begin
          size = '0;
          wptr = 1'b0;
        end
        if (gen_transaction == TT2_TRANSLATION_SYNC) begin
          size = '0;
          wptr = 1'b0;
          top = '0;
          addr = '0;
        end
      end
      KIND_WRITE: begin
        fmt = FMT_WRITE;
        payload = 1'b1;
      end
      KIND_RESPONSE: begin
        // Answers carry the requester's tag, the status in the size slot and no address.
        fmt = FMT_RESPONSE;
        payload = gen_has_payload && gen_status != ST_FAULT;
        tt = payload ? TT13_WITH_DATA : TT13_NO_DATA;
        size = gen_status;
        wptr = 1'b0;
        top = '0;
        addr = '0;
      end
      default: fmt = FMT_REQUEST;
    endcase
    header = {fmt, tt, dom, dev, orig_tag, gen_tag, size, wptr, top, addr};
  end

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_count = count;
    next_refused = 1'b0;
    next_payload = tx_payload_follows;
    next_tx_valid = tx_valid;
    next_tx_bit = tx_bit;
    next_tx_last = tx_last;
    case (state)
      S_IDLE: begin
        if (gen_valid) begin
          if (legal_request(gen_kind, gen_transaction, gen_status, role)) begin
            next_state = S_SHIFT;
            next_shift = header << 1;
            next_count = '0;
            next_tx_valid = 1'b1;
            next_tx_bit = header[HDR_W-1];
            next_tx_last = 1'b0;
            next_payload = payload;
          end else begin
            next_refused = 1'b1;
          end
        end
      end
      S_SHIFT: begin
        if (tx_ready) begin
          if (count == LAST_BIT) begin
            next_state = S_IDLE;
            next_tx_valid = 1'b0;
            next_tx_last = 1'b0;
            next_tx_bit = 1'b0;
            next_payload = 1'b0;
          end else begin
            next_count = count + 1'b1;
            next_tx_bit = shift[HDR_W-1];
            next_shift = shift << 1;
            next_tx_last = (count + 1'b1) == LAST_BIT;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    next_gen_ready = next_state == S_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      shift <= '0;
      count <= '0;
      gen_ready <= 1'b1;
      gen_refused <= 1'b0;
      tx_valid <= 1'b0;
      tx_bit <= 1'b0;
      tx_last <= 1'b0;
      tx_payload_follows <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      count <= next_count;
      gen_ready <= next_gen_ready;
      gen_refused <= next_refused;
      tx_valid <= next_tx_valid;
      tx_bit <= next_tx_bit;
      tx_last <= next_tx_last;
      tx_payload_follows <= next_payload;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  coherent_rx_checker u_rx_checker (
    .clk(clk),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_format(rx_format),
    .rx_transaction(rx_transaction),
    .rx_status(rx_status),
    .rx_accept(rx_accept),
    .rx_impl_defined(rx_impl_defined),
    .rx_error(rx_error)
  );

endmodule
`default_nettype wire

// ===== codec_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module codec_checker
  import coherent_codec_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire role_e role, // Role.
  input wire logic gen_valid, // Request.
  input wire kind_e gen_kind, // Class.
  input wire logic [TT_W-1:0] gen_transaction, // Code.
  input wire logic [ST_W-1:0] gen_status, // Status.
  input wire logic tx_ready, // Sink ready.
  input wire logic gen_ready, // Idle.
  input wire logic gen_refused, // Refusal.
  input wire logic tx_valid, // Stream on.
  input wire logic tx_bit, // Bit.
  input wire logic tx_last, // Last bit.
  input wire logic tx_payload_follows, // Payload.
  input wire logic rx_valid, // Rx header.
  input wire logic [FMT_W-1:0] rx_format, // Rx format.
  input wire logic rx_accept, // Accept.
  input wire logic rx_impl_defined, // Impl.
  input wire logic rx_error // Error.
);
  logic take;
  logic bad;
  logic [3:0] fmt;
  logic [3:0] next_fmt;
  logic [6:0] idx;
  logic [6:0] next_idx;

  // Legality is worked out apart from the design, so a wrong refusal table shows up here.
  always_comb begin
    take = gen_valid && gen_ready;
    case (gen_kind)
      KIND_INTERVENTION: bad = role != ROLE_HOME || gen_transaction > 4'h2;
      KIND_REQUEST: bad = gen_transaction == 4'h4 || gen_transaction > 4'hB
        || (gen_transaction > 4'h9 && role != ROLE_HOME);
      KIND_WRITE: bad = gen_transaction > 4'h1;
      default: bad = gen_status == 4'h6 || (gen_status > 4'h7 && gen_status < 4'hC);
    endcase
    next_fmt = !take ? fmt : gen_kind == KIND_INTERVENTION ? 4'h1 : gen_kind == KIND_REQUEST ? 4'h2
      : gen_kind == KIND_WRITE ? 4'h5 : 4'hD;
    next_idx = !tx_valid ? 7'h00 : tx_ready ? idx + 7'h01 : idx;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt <= 4'h0;
      idx <= 7'h00;
    end else begin
      fmt <= next_fmt;
      idx <= next_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  lead_format_a: assert property (tx_valid && idx < 7'h04 |-> tx_bit == fmt[2'h3 - idx[1:0]])
    else $error("format bits out of order");
  header_length_a: assert property (tx_valid && tx_last |-> idx == 7'h43)
    else $error("header length wrong");
  home_only_a: assert property (take && gen_kind == KIND_INTERVENTION && role != ROLE_HOME |=> gen_refused)
    else $error("intervention sent by non-home element");
  reserved_code_a: assert property (take && bad |=> gen_refused && !tx_valid)
    else $error("reserved code not refused");
  legal_start_a: assert property (take && !bad |=> tx_valid && !gen_ready && !gen_refused)
    else $error("legal request not started");
  write_payload_a: assert property (take && !bad && gen_kind == KIND_WRITE |=> tx_payload_follows)
    else $error("write without payload");
  fault_payload_a: assert property (take && gen_kind == KIND_RESPONSE && gen_status == ST_FAULT
    |=> tx_valid && !tx_payload_follows)
    else $error("fault response with payload");
  bit_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_bit))
    else $error("bit changed while stalled");
  stream_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid && gen_ready)
    else $error("stream did not end");
  rx_one_result_a: assert property (rx_valid |=> $onehot({rx_accept, rx_impl_defined, rx_error}))
    else $error("checker result not unique");
  rx_impl_a: assert property (rx_valid && rx_format == 4'hF |=> rx_impl_defined)
    else $error("format 15 not implementation defined");
  rx_reserved_a: assert property (rx_valid && rx_format inside {4'h3, 4'h4, [4'h6:4'hC], 4'hE}
    |=> rx_error)
    else $error("reserved format not flagged");

  refuse_c: cover property (take && bad ##1 gen_refused);
  reply_data_c: cover property (tx_valid && tx_payload_follows && fmt == 4'hD);
  impl_c: cover property (rx_impl_defined);
endmodule

bind coherent_memory_packet_codec codec_checker chk (.clk(clk), .rst_n(rst_n), .role(role),
  .gen_valid(gen_valid), .gen_kind(gen_kind), .gen_transaction(gen_transaction), .gen_status(gen_status),
  .tx_ready(tx_ready), .gen_ready(gen_ready), .gen_refused(gen_refused), .tx_valid(tx_valid),
  .tx_bit(tx_bit), .tx_last(tx_last), .tx_payload_follows(tx_payload_follows), .rx_valid(rx_valid),
  .rx_format(rx_format), .rx_accept(rx_accept), .rx_impl_defined(rx_impl_defined), .rx_error(rx_error));
`default_nettype wire

// ===== serial_sink.sv
`timescale 1ns/1ps
`default_nettype none
module serial_sink #(
  parameter int SEED = 43
) (
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic slow, // Random stalls.
  input wire logic tx_valid, // Stream on.
  input wire logic tx_bit, // Bit.
  input wire logic tx_last, // Last bit.
  output logic tx_ready, // Takes bit.
  output logic [67:0] pkt, // Whole header.
  output logic done, // Header pulse.
  output logic [7:0] nbits // Bits counted.
);
  integer seed = SEED;
  logic [67:0] shift;
  logic [7:0] cnt;

  // Bits arrive first to last, so the first bit ends at the top of the word.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      shift <= '0;
      cnt <= 8'h00;
      done <= 1'b0;
      pkt <= '0;
      nbits <= 8'h00;
    end else begin
      tx_ready <= slow ? ($random(seed) & 1) != 0 : 1'b1;
      done <= 1'b0;
      if (tx_valid && tx_ready) begin
        shift <= {shift[66:0], tx_bit};
        cnt <= tx_last ? 8'h00 : cnt + 8'h01;
        if (tx_last) begin
          pkt <= {shift[66:0], tx_bit};
          nbits <= cnt + 8'h01;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import coherent_codec_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, gen_valid = 1'b0, pl = 1'b0, wp = 1'b0, slow = 1'b0, rx_valid = 1'b0;
  role_e role = ROLE_REQUESTER;
  kind_e kind = KIND_INTERVENTION;
  logic [3:0] tt = 4'h0, st = 4'h0, sz = 4'h0, dom = 4'h0, dev = 4'h0, rx_format = 4'h0, rx_tt = 4'h0;
  logic [3:0] rx_st = 4'h0;
  logic [1:0] top = 2'h0;
  logic [7:0] tag = 8'h00, otag = 8'h00, nbits;
  logic [28:0] addr = 29'h0;
  logic tx_ready, gen_ready, gen_refused, tx_valid, tx_bit, tx_last, tx_payload_follows, done;
  logic rx_accept, rx_impl_defined, rx_error;
  logic [67:0] pkt;
  logic [2:0] exp_rx;
  integer seed = 43;
  int err_total = 0;
  int checks_done = 0;

  coherent_memory_packet_codec uut (.clk(clk), .rst_n(rst_n), .role(role), .gen_valid(gen_valid),
    .gen_kind(kind), .gen_transaction(tt), .gen_status(st), .gen_has_payload(pl), .gen_size(sz),
    .gen_word_pointer(wp), .gen_address(addr), .gen_address_top(top), .gen_tag(tag),
    .gen_original_domain(dom), .gen_original_device(dev), .gen_original_tag(otag), .tx_ready(tx_ready),
    .gen_ready(gen_ready), .gen_refused(gen_refused), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_last(tx_last), .tx_payload_follows(tx_payload_follows), .rx_valid(rx_valid),
    .rx_format(rx_format), .rx_transaction(rx_tt), .rx_status(rx_st), .rx_accept(rx_accept),
    .rx_impl_defined(rx_impl_defined), .rx_error(rx_error));
  serial_sink sink (.clk(clk), .rst_n(rst_n), .slow(slow), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_last(tx_last), .tx_ready(tx_ready), .pkt(pkt), .done(done), .nbits(nbits));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic bit exp_bad();
    case (kind)
      KIND_INTERVENTION: return role != ROLE_HOME || tt > 4'h2;
      KIND_REQUEST: return tt == 4'h4 || tt > 4'hB || (tt > 4'h9 && role != ROLE_HOME);
      KIND_WRITE: return tt > 4'h1;
      default: return st == 4'h6 || (st > 4'h7 && st < 4'hC);
    endcase
  endfunction

  function automatic bit exp_pl();
    return kind == KIND_WRITE || (kind == KIND_RESPONSE && pl && st != 4'h7);
  endfunction

  function automatic logic [67:0] exp_hdr();
    logic [3:0] f, t, d, v, s;
    logic [7:0] o;
    logic w;
    logic [1:0] x;
    logic [28:0] a;
    {f, t, d, v, o, s, w, x, a} = {4'h1, tt, dom, dev, otag, sz, wp, top, addr};
    if (kind != KIND_INTERVENTION) begin
      {d, v, o} = 16'h0000;
      f = kind == KIND_REQUEST ? 4'h2 : kind == KIND_WRITE ? 4'h5 : 4'hD;
    end
    if (kind == KIND_REQUEST && tt inside {4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB}) {s, w} = 5'h00;
    if (kind == KIND_REQUEST && tt == 4'h7) {x, a} = 31'h0;
    if (kind == KIND_RESPONSE) begin
      t = exp_pl() ? 4'h8 : 4'h0;
      s = st;
      {w, x, a} = 32'h0;
    end
    return {f, t, d, v, o, tag, s, w, x, a};
  endfunction

  function automatic logic [2:0] rx_model(logic [11:0] v);
    bit bad;
    if (v[11:8] == 4'h0 || v[11:8] == 4'hF) return 3'b010;
    case (v[11:8])
      4'h1: bad = v[7:4] > 4'h2;
      4'h2: bad = v[7:4] == 4'h4 || v[7:4] > 4'hB;
      4'h5: bad = v[7:4] > 4'h1;
      4'hD: bad = (v[7:4] != 4'h0 && v[7:4] != 4'h8) || v[3:0] == 4'h6 || (v[3:0] > 4'h7 && v[3:0] < 4'hC);
      default: bad = 1'b1;
    endcase
    return bad ? 3'b001 : 3'b100;
  endfunction

  task automatic chk(input logic [67:0] seen, input logic [67:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic hang();
    err_total++;
    close_out();
  endtask

  // A response carries its status in the size slot, so every header is compared whole.
  task automatic send(input int k, input int r, input int t);
    int n;
    logic [63:0] rnd;
    n = 0;
    rnd = {$random(seed), $random(seed)};
    while (gen_ready !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > 300) hang();
    end
    @(posedge clk);
    kind <= kind_e'(k[1:0]);
    role <= role_e'(r[1:0]);
    {tt, st} <= {t[3:0], t[3:0]};
    {pl, wp, sz, top, addr, tag, otag, dom, dev} <= rnd[60:0];
    slow <= r == 1;
    gen_valid <= 1'b1;
    @(posedge clk);
    gen_valid <= 1'b0;
    #1 chk({67'h0, gen_refused}, {67'h0, exp_bad()});
    if (!exp_bad()) begin
      chk({67'h0, tx_payload_follows}, {67'h0, exp_pl()});
      n = 0;
      while (done !== 1'b1) begin
        @(posedge clk);
        #1 n++;
        if (n > 1000) hang();
      end
      chk(pkt, exp_hdr());
      chk({60'h0, nbits}, 68'h44);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) for (int r = 0; r < 3; r++) for (int t = 0; t < 16; t++) send(k, r, t);
    // Every format, code and status goes past the checker back to back, one header per cycle.
    exp_rx = 3'b000;
    for (int i = 0; i <= 4096; i++) begin
      @(posedge clk);
      rx_valid <= i < 4096;
      {rx_format, rx_tt, rx_st} <= i[11:0];
      #1 chk({65'h0, rx_accept, rx_impl_defined, rx_error}, {65'h0, exp_rx});
      exp_rx = i < 4096 ? rx_model(i[11:0]) : 3'b000;
    end
    // A reset in mid-stream must drop the header and leave the generator idle.
    @(posedge clk);
    kind <= KIND_WRITE;
    role <= ROLE_HOME;
    tt <= 4'h0;
    gen_valid <= 1'b1;
    @(posedge clk);
    gen_valid <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 chk({66'h0, gen_ready, tx_valid}, {66'h0, 2'b10});
    rst_n <= 1'b1;
    send(2, 1, 1);
    close_out();
  end
endmodule
`default_nettype wire
